// [hdl/diag_alarm_unit.sv]
// Purpose: diagnostic alarm flags with AXI4-Lite status and control
// Assumes: all inputs synchronous to aclk; monitors deliver digitised results
// Notes: ce low freezes every flip-flop while aresetn is high
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "diag_defines.svh"

module diag_alarm_unit #(
	parameter int DATA_W = 16,
	parameter int FREQ_W = 16,
	parameter int MEAN_W = 16
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial link integrity
	input wire logic xfer_done,
	input wire logic xfer_bad,
	// shadow register bank ecc
	input wire diag_pkg::ecc_ev_s shadow_ev,
	input wire logic [DATA_W-1:0] shadow_word,
	input wire logic [$clog2(DATA_W)-1:0] shadow_err_pos,
	output logic [DATA_W-1:0] shadow_fixed,
	// nonvolatile memory ecc
	input wire logic startup_active,
	input wire diag_pkg::ecc_ev_s nvm_ev,
	input wire logic [DATA_W-1:0] nvm_word,
	input wire logic [$clog2(DATA_W)-1:0] nvm_err_pos,
	output logic [DATA_W-1:0] nvm_fixed,
	// transmitter oscillator
	input wire logic [FREQ_W-1:0] freq_meas,
	input wire logic osc_running,
	// analog output mean check, signed offsets from half supply
	input wire logic mean_chk,
	input wire logic signed [MEAN_W-1:0] mean_sine,
	input wire logic signed [MEAN_W-1:0] mean_cosine,
	output logic analog_out_en,
	// alarm
	output logic alarm_request_pin_n
);
	import diag_pkg::*;

	function automatic logic [DATA_W-1:0] fix_word(input logic [DATA_W-1:0] w,
			input logic [$clog2(DATA_W)-1:0] pos, input logic sed);
		fix_word = sed ? (w ^ (DATA_W'(1) << pos)) : w;
	endfunction

	function automatic logic [MEAN_W-1:0] magnitude(input logic signed [MEAN_W-1:0] v);
		magnitude = v[MEAN_W-1] ? MEAN_W'(-v) : MEAN_W'(v);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
		merge = old;
	endfunction

	// ---- bus slave state
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	rd_state_e rd_q, rd_d;
	logic wr_fire;

	// ---- control registers
	logic [9:0] alarm_en_q, alarm_en_d;
	logic [31:0] freq_lim_q, freq_lim_d;
	logic [15:0] wdog_val_q, wdog_val_d;
	logic [15:0] mean_lim_q, mean_lim_d;
	logic perm_clr;

	// ---- diagnostic state
	flag_s flags_q, flags_d;
	logic [15:0] wdog_cnt_q, wdog_cnt_d;
	logic [3:0] fail_cnt_q, fail_cnt_d;
	logic [DATA_W-1:0] shadow_fixed_d, nvm_fixed_d;
	logic out_en_d, pin_n_d;
	logic [FREQ_W-1:0] freq_lo, freq_hi;
	logic mean_bad;

	assign wr_fire = aw_got_q && w_got_q && !bvalid;

	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid;
		bresp_d = bresp;
		alarm_en_d = alarm_en_q;
		freq_lim_d = freq_lim_q;
		wdog_val_d = wdog_val_q;
		mean_lim_d = mean_lim_q;
		perm_clr = 1'b0;
		if (awvalid && awready) begin
			aw_got_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_got_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `RESP_OKAY;
			unique case (aw_addr_q)
				`OFS_FLAGS: perm_clr = w_strb_q[1] && w_data_q[`FLAG_OUT_PERM_BIT];
				`OFS_ALARM_EN: alarm_en_d = 10'(merge(32'(alarm_en_q), w_data_q, w_strb_q));
				`OFS_FREQ_LIM: freq_lim_d = merge(freq_lim_q, w_data_q, w_strb_q);
				`OFS_WDOG_VAL: wdog_val_d = 16'(merge(32'(wdog_val_q), w_data_q, w_strb_q));
				`OFS_MEAN_LIM: mean_lim_d = 16'(merge(32'(mean_lim_q), w_data_q, w_strb_q));
				`OFS_FREQ_MEAS: ;
				default: bresp_d = `RESP_SLVERR;
			endcase
		end else if (bvalid && bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_comb begin
		rd_d = rd_q;
		rdata_d = rdata;
		rresp_d = rresp;
		unique case (rd_q)
			RD_IDLE: if (arvalid && arready) begin
				rd_d = RD_RESP;
				rresp_d = `RESP_OKAY;
				unique case (araddr)
					`OFS_FLAGS: rdata_d = 32'(flags_q);
					`OFS_ALARM_EN: rdata_d = 32'(alarm_en_q);
					`OFS_FREQ_LIM: rdata_d = freq_lim_q;
					`OFS_WDOG_VAL: rdata_d = 32'(wdog_val_q);
					`OFS_MEAN_LIM: rdata_d = 32'(mean_lim_q);
					`OFS_FREQ_MEAS: rdata_d = 32'(freq_meas);
					default: begin
						rdata_d = 32'h0000_0000;
						rresp_d = `RESP_SLVERR;
					end
				endcase
			end
			RD_RESP: if (rready) begin
				rd_d = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			awready <= 1'b0;
			wready <= 1'b0;
			rd_q <= RD_IDLE;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
			alarm_en_q <= `ALARM_EN_RST;
			freq_lim_q <= `FREQ_LIM_RST;
			wdog_val_q <= `WDOG_VAL_RST;
			mean_lim_q <= `MEAN_LIM_RST;
		end else if (ce) begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid <= bvalid_d;
			bresp <= bresp_d;
			awready <= !aw_got_d && !bvalid_d && !(awvalid && awready);
			wready <= !w_got_d && !bvalid_d && !(wvalid && wready);
			rd_q <= rd_d;
			arready <= (rd_d == RD_IDLE) && !(arvalid && arready);
			rvalid <= (rd_d == RD_RESP);
			rdata <= rdata_d;
			rresp <= rresp_d;
			alarm_en_q <= alarm_en_d;
			freq_lim_q <= freq_lim_d;
			wdog_val_q <= wdog_val_d;
			mean_lim_q <= mean_lim_d;
		end
	end

	// ---- diagnostics
	assign freq_lo = freq_lim_q[`FREQ_LO_POS +: FREQ_W];
	assign freq_hi = freq_lim_q[`FREQ_HI_POS +: FREQ_W];
	assign mean_bad = (magnitude(mean_sine) > MEAN_W'(mean_lim_q))
		|| (magnitude(mean_cosine) > MEAN_W'(mean_lim_q));

	always_comb begin
		flags_d = flags_q;
		wdog_cnt_d = wdog_cnt_q;
		fail_cnt_d = fail_cnt_q;
		if (xfer_done) flags_d.proto = xfer_bad;
		if (shadow_ev.chk) begin
			flags_d.shadow_sed = shadow_ev.sed;
			flags_d.shadow_ded = flags_q.shadow_ded | shadow_ev.ded;
		end
		if (startup_active && nvm_ev.chk) begin
			flags_d.nvm_sed = nvm_ev.sed;
			flags_d.nvm_ded = flags_q.nvm_ded | nvm_ev.ded;
		end
		flags_d.osc_freq = (freq_meas < freq_lo) || (freq_meas > freq_hi);
		flags_d.osc_stall = !osc_running;
		if (wdog_val_q == 16'h0000) begin
			wdog_cnt_d = 16'h0000;
		end else if (wdog_cnt_q == 16'h0000) begin
			wdog_cnt_d = wdog_val_q;
		end else if (wdog_cnt_q == 16'h0001) begin
			flags_d.wdog = 1'b1;
			wdog_cnt_d = wdog_val_q;
		end else begin
			wdog_cnt_d = wdog_cnt_q - 16'h0001;
		end
		if (perm_clr) begin
			flags_d.out_perm = 1'b0;
			fail_cnt_d = 4'h0;
		end
		if (mean_chk) begin
			flags_d.out_temp = mean_bad;
			if (!mean_bad) begin
				fail_cnt_d = 4'h0;
			end else if (fail_cnt_d != `FAIL_CHECKS) begin
				fail_cnt_d = fail_cnt_d + 4'h1;
			end
			if (mean_bad && fail_cnt_d == `FAIL_CHECKS) flags_d.out_perm = 1'b1;
		end
		shadow_fixed_d = fix_word(shadow_word, shadow_err_pos, shadow_ev.sed);
		nvm_fixed_d = fix_word(nvm_word, nvm_err_pos, nvm_ev.sed);
		out_en_d = !(flags_d.out_temp || flags_d.out_perm);
		pin_n_d = !(|(10'(flags_d) & alarm_en_q));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= '0;
			wdog_cnt_q <= 16'h0000;
			fail_cnt_q <= 4'h0;
			shadow_fixed <= '0;
			nvm_fixed <= '0;
			analog_out_en <= 1'b0;
			alarm_request_pin_n <= 1'b1;
		end else if (ce) begin
			flags_q <= flags_d;
			wdog_cnt_q <= wdog_cnt_d;
			fail_cnt_q <= fail_cnt_d;
			shadow_fixed <= shadow_fixed_d;
			nvm_fixed <= nvm_fixed_d;
			analog_out_en <= out_en_d;
			alarm_request_pin_n <= pin_n_d;
		end
	end

	// ---- checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	a_proto_flag: assert property (xfer_done ##1 ce |-> flags_q.proto == $past(xfer_bad))
		else $error("integrity flag does not follow transfer result");
	a_static_hold: assert property (flags_q.shadow_ded |=> flags_q.shadow_ded)
		else $error("static shadow flag dropped");
	a_sec_fix: assert property (shadow_ev.sed |=> shadow_fixed
			== ($past(shadow_word) ^ (DATA_W'(1) << $past(shadow_err_pos))))
		else $error("shadow word not corrected");
	a_nvm_window: assert property (!startup_active |=> $stable(flags_q.nvm_sed))
		else $error("memory flag changed outside start-up");
	a_freq_range: assert property (freq_meas > freq_hi && $stable(freq_lim_q)
			|=> flags_q.osc_freq)
		else $error("frequency above bound not flagged");
	a_stall_flag: assert property (!osc_running |=> flags_q.osc_stall)
		else $error("stall not flagged");
	a_wdog_expire: assert property (wdog_cnt_q == 16'h0001 && wdog_val_q != 16'h0000
			|=> flags_q.wdog && wdog_cnt_q == $past(wdog_val_q))
		else $error("watchdog expiry wrong");
	a_wdog_halt: assert property (wdog_val_q == 16'h0000 |=> wdog_cnt_q == 16'h0000)
		else $error("watchdog runs with zero value");
	a_out_off: assert property (flags_q.out_temp || flags_q.out_perm |-> !analog_out_en)
		else $error("analog outputs on during failure");
	a_perm_eight: assert property (mean_chk && mean_bad && fail_cnt_q == 4'h7 && !perm_clr
			|=> flags_q.out_perm && !analog_out_en)
		else $error("no shutdown after eight failures");
	a_fail_reset: assert property (mean_chk && !mean_bad |=> fail_cnt_q == 4'h0)
		else $error("failure count not reset");
	a_pin_map: assert property (alarm_request_pin_n == !(|(10'(flags_q) & $past(alarm_en_q))))
		else $error("alarm pin mismatch");

	c_wdog_cycle: cover property (flags_q.wdog && wdog_val_q != 16'h0000);
	c_perm_off: cover property (flags_q.out_perm ##1 !flags_q.out_perm);
	c_pin_low: cover property (!alarm_request_pin_n);
	c_slverr: cover property (rvalid && rresp == `RESP_SLVERR);

endmodule // diag_alarm_unit

// [hdl/diag_defines.svh]
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 32-bit AXI4-Lite data, word-aligned registers
// Notes: definitions only
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH

`define OFS_FLAGS 8'h00
`define OFS_ALARM_EN 8'h04
`define OFS_FREQ_LIM 8'h08
`define OFS_WDOG_VAL 8'h0C
`define OFS_MEAN_LIM 8'h10
`define OFS_FREQ_MEAS 8'h14

`define FLAG_OUT_PERM_BIT 9
`define FREQ_LO_POS 0
`define FREQ_HI_POS 16

`define ALARM_EN_RST 10'h3FF
`define FREQ_LIM_RST 32'hFFFF_0000
`define WDOG_VAL_RST 16'h0000
`define MEAN_LIM_RST 16'h0100

`define FAIL_CHECKS 4'h8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [hdl/diag_pkg.sv]
// Purpose: shared types of the diagnostic flag unit
// Assumes: nothing
// Notes: flag order fixes the status register layout, bit 9 first
package diag_pkg;

	typedef struct packed {
		logic out_perm;
		logic out_temp;
		logic wdog;
		logic osc_stall;
		logic osc_freq;
		logic nvm_sed;
		logic nvm_ded;
		logic shadow_sed;
		logic shadow_ded;
		logic proto;
	} flag_s;

	typedef struct packed {
		logic chk;
		logic sed;
		logic ded;
	} ecc_ev_s;

	typedef enum logic [0:0] {
		RD_IDLE,
		RD_RESP
	} rd_state_e;

endpackage

// [dv/host_model.sv]
// Purpose: host side of the register bus
// Assumes: one write and one read at a time
// Notes: a hung access ends the run
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic aclk,
	// write
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		r = bresp;
		bready <= 1'b0;
		if (!bvalid) tb_diag_alarm_flag_unit.close_out(1'b1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (!rvalid) tb_diag_alarm_flag_unit.close_out(1'b1);
	endtask
endmodule // host_model

// [dv/tb_diag_alarm_flag_unit.sv]
// Purpose: self-checking bench of the diagnostic flag unit
// Assumes: default widths, ce high except for one freeze step
// Notes: flags tracked by hand per step
`timescale 1ns/1ps
`include "diag_defines.svh"
module tb_diag_alarm_flag_unit;
	import diag_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, shadow_err_pos = '0, nvm_err_pos = '0, p;
	logic [1:0] bresp, rresp;
	logic xfer_done = 1'b0, xfer_bad = 1'b0, startup_active = 1'b0, osc_running = 1'b1;
	logic mean_chk = 1'b0, analog_out_en, alarm_request_pin_n;
	ecc_ev_s shadow_ev = '0, nvm_ev = '0;
	logic [15:0] shadow_word = '0, nvm_word = '0, shadow_fixed, nvm_fixed, w;
	logic [15:0] freq_meas = 16'h0096;
	logic [15:0] lims [4] = '{16'h0063, 16'h00C9, 16'h0064, 16'h00C8};
	logic signed [15:0] mean_sine = '0, mean_cosine = '0;
	int fail_count = 0, total_checks = 0, i;
	always #5 aclk = ~aclk;
	diag_alarm_unit dut_u (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .xfer_done, .xfer_bad, .shadow_ev, .shadow_word,
		.shadow_err_pos, .shadow_fixed, .startup_active, .nvm_ev, .nvm_word, .nvm_err_pos,
		.nvm_fixed, .freq_meas, .osc_running, .mean_chk, .mean_sine, .mean_cosine,
		.analog_out_en, .alarm_request_pin_n);
	host_model host_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready);
	function automatic logic [15:0] fix(input logic [15:0] v, input logic [3:0] b);
		return v ^ (16'h0001 << b);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out(input bit hung);
		if (hung) fail_count++;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic [1:0] r;
		host_u.wr(a, v, r);
		chk("bresp", 32'(r), 32'(er));
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host_u.rd(a, d, r);
		chk("rdata", d, ev);
		chk("rresp", 32'(r), 32'(er));
	endtask
	task automatic settle;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic fl(input logic [31:0] ev);
		rdc(8'h00, ev, `RESP_OKAY);
	endtask
	task automatic mc(input logic [15:0] s, input logic [15:0] c);
		@(posedge aclk);
		mean_chk <= 1'b1;
		mean_sine <= s;
		mean_cosine <= c;
		@(posedge aclk);
		mean_chk <= 1'b0;
	endtask
	task automatic xf(input logic bad);
		@(posedge aclk);
		xfer_done <= 1'b1;
		xfer_bad <= bad;
		@(posedge aclk);
		xfer_done <= 1'b0;
		settle();
	endtask
	task automatic ecc(input bit nv, input ecc_ev_s ev);
		w = 16'($urandom);
		p = 4'($urandom);
		@(posedge aclk);
		shadow_word <= w;
		nvm_word <= w;
		shadow_err_pos <= p;
		nvm_err_pos <= p;
		if (nv) nvm_ev <= ev;
		else shadow_ev <= ev;
		@(posedge aclk);
		shadow_ev <= '0;
		nvm_ev <= '0;
		@(negedge aclk);
	endtask
	task automatic pins(input logic pin, input logic aout);
		settle();
		chk("pin", 32'(alarm_request_pin_n), 32'(pin));
		chk("aout", 32'(analog_out_en), 32'(aout));
	endtask
	initial begin
		void'($urandom(32'h102FE81A));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		pins(1'b1, 1'b1);
		rdc(8'h04, 32'(`ALARM_EN_RST), `RESP_OKAY);
		rdc(8'h08, `FREQ_LIM_RST, `RESP_OKAY);
		rdc(8'h0C, 32'h0, `RESP_OKAY);
		rdc(8'h10, 32'(`MEAN_LIM_RST), `RESP_OKAY);
		fl(32'h0);
		rdc(8'h18, 32'h0, `RESP_SLVERR);
		wr(8'h18, 32'hFFFFFFFF, `RESP_SLVERR);
		wr(8'h14, 32'h0, `RESP_OKAY);
		rdc(8'h14, 32'(freq_meas), `RESP_OKAY);
		mc(16'h0101, 16'h0000);
		pins(1'b0, 1'b0);
		fl(32'h100);
		mc(16'h0100, 16'hFF00);
		pins(1'b1, 1'b1);
		for (i = 0; i < 16; i++) mc((i % 8 == 7) ? 16'h0000 : 16'h0101, 16'h0000);
		fl(32'h0);
		for (i = 0; i < 8; i++) mc(16'h0000, 16'hFEFF);
		fl(32'h300);
		mc(16'h0000, 16'h0000);
		pins(1'b0, 1'b0);
		fl(32'h200);
		wr(8'h00, 32'h0000_0200, `RESP_OKAY);
		pins(1'b1, 1'b1);
		fl(32'h0);
		xf(1'b1);
		fl(32'h1);
		xf(1'b0);
		fl(32'h0);
		wr(8'h08, 32'h00C8_0064, `RESP_OKAY);
		for (i = 0; i < 7; i++) begin
			w = (i < 4) ? lims[i] : 16'h0064 + 16'($urandom_range(100));
			if (i == 6) w = 16'h0063;
			@(posedge aclk);
			freq_meas <= w;
			settle();
			fl((w < 16'h0064 || w > 16'h00C8) ? 32'h20 : 32'h0);
		end
		wr(8'h04, 32'h0000_03DF, `RESP_OKAY);
		pins(1'b1, 1'b1);
		wr(8'h04, 32'h0000_03FF, `RESP_OKAY);
		pins(1'b0, 1'b1);
		@(posedge aclk);
		osc_running <= 1'b0;
		settle();
		fl(32'h60);
		@(posedge aclk);
		osc_running <= 1'b1;
		freq_meas <= 16'h0096;
		settle();
		fl(32'h0);
		ecc(1'b0, 3'b110);
		chk("sfix", 32'(shadow_fixed), 32'(fix(w, p)));
		fl(32'h4);
		ecc(1'b0, 3'b101);
		ecc(1'b0, 3'b100);
		fl(32'h2);
		ecc(1'b1, 3'b101);
		fl(32'h2);
		@(posedge aclk);
		startup_active <= 1'b1;
		ecc(1'b1, 3'b110);
		chk("nfix", 32'(nvm_fixed), 32'(fix(w, p)));
		fl(32'h12);
		ecc(1'b1, 3'b101);
		fl(32'h0A);
		wr(8'h0C, 32'h0000_0014, `RESP_OKAY);
		fl(32'h0A);
		repeat (25) @(posedge aclk);
		fl(32'h8A);
		wr(8'h0C, 32'h0, `RESP_OKAY);
		rdc(8'h0C, 32'h0, `RESP_OKAY);
		// a bad transfer while ce is low must leave every flag frozen
		@(posedge aclk);
		ce <= 1'b0;
		xf(1'b1);
		@(posedge aclk);
		ce <= 1'b1;
		fl(32'h8A);
		// permanent shutdown again, then cleared by reset instead of the host
		for (i = 0; i < 8; i++) mc(16'h0000, 16'hFEFF);
		pins(1'b0, 1'b0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		pins(1'b1, 1'b1);
		fl(32'h0);
		close_out(1'b0);
	end
endmodule // tb_diag_alarm_flag_unit
